// *** verilog/tbah_defs.svh ***
// Constants of the Type B anticollision handler: offsets, codes, field positions, reset values
`ifndef TBAH_DEFS_SVH
`define TBAH_DEFS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define TBAH_REG_AFI      8'h00
`define TBAH_REG_UID_LO   8'h04
`define TBAH_REG_UID_HI   8'h08
`define TBAH_REG_APP      8'h0c
`define TBAH_REG_STATUS   8'h10
// ==========================================================
// Reset values
`define TBAH_AFI_RST      8'h00
`define TBAH_UID_RST      32'h0000_0000
`define TBAH_APP_RST      32'h0000_0000
`define TBAH_LFSR_SEED    16'hace1
// ==========================================================
// Command and answer codes
`define TBAH_CMD_REQ      8'h05
`define TBAH_CMD_HALT     8'h50
`define TBAH_CMD_ATTRIB   8'h1d
`define TBAH_CMD_DESEL    8'hc2
`define TBAH_CMD_DESEL_C  8'hca
`define TBAH_MARK_LOW     4'h5
`define TBAH_ATQB_IND     8'h50
`define TBAH_HALT_ANS     8'h00
`define TBAH_PI_RATE      8'h77
`define TBAH_PI_SIZE      8'h21
`define TBAH_PI_FWI       4'h7
`define TBAH_PI_ADC       2'h0
`define TBAH_PI_FO        2'h1
// ==========================================================
// Field positions and sizes
`define TBAH_PAR_WUPB     3
`define TBAH_N_MAX_CODE   3'h4
`define TBAH_PCB_CID      3
`define TBAH_MAX_FRAME    5'h1a
`define TBAH_RX_KEEP      9
`define TBAH_TX_KEEP      12
`endif

// *** verilog/tbah_pkg.sv ***
// Types shared by the Type B anticollision handler modules
package tbah_pkg;
  // Gray coded along IDLE -> WAIT -> READY -> ACTIVE -> HALT
  typedef enum logic [2:0] {
    TBAH_IDLE   = 3'h0,
    TBAH_WAIT   = 3'h1,
    TBAH_READY  = 3'h3,
    TBAH_ACTIVE = 3'h2,
    TBAH_HALT   = 3'h6
  } tbah_state_t;
  typedef enum logic [1:0] {
    TBAH_ANS_ATQB = 2'h0,
    TBAH_ANS_HALT = 2'h1,
    TBAH_ANS_ATTR = 2'h2,
    TBAH_ANS_DESL = 2'h3
  } tbah_ans_t;
endpackage

// *** verilog/tbah_byte_if.sv ***
// Byte stream between the handler core and its link serialisers
`timescale 1ns/1ps
interface tbah_byte_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       eof;
  logic       crc_ok;
  modport src (output valid, output data, output eof, output crc_ok, input ready);
  modport snk (input valid, input data, input eof, input crc_ok, output ready);
endinterface

// *** verilog/tbah_link_rx.sv ***
// Link receiver: samples link pins, assembles bytes LSB first, flags frame end
`timescale 1ns/1ps
`include "tbah_defs.svh"
module tbah_link_rx (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic ce_in,
  input  wire logic link_clk_in,
  input  wire logic link_data_in,
  input  wire logic link_frame_in,
  input  wire logic link_crc_ok_in,
  tbah_byte_if.src  rx
);
  logic [3:0] s1_q, s2_q;
  logic       clk_prev_q, frm_prev_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic       valid_q, eof_q, crc_q;
  logic       rise, frm_fall;
  // ==========================================================
  // Two-stage synchronisers; only the second stage is looked at
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end else if (ce_in) begin
      s1_q <= {link_crc_ok_in, link_frame_in, link_data_in, link_clk_in};
      s2_q <= s1_q;
    end
  end
  assign rise     = s2_q[0] & ~clk_prev_q;
  assign frm_fall = ~s2_q[2] & frm_prev_q;
  // ==========================================================
  // Bit assembly; a partial byte at frame end is dropped
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      clk_prev_q <= 1'b0;
      frm_prev_q <= 1'b0;
      sh_q       <= 8'h00;
      cnt_q      <= 3'h0;
      valid_q    <= 1'b0;
      eof_q      <= 1'b0;
      crc_q      <= 1'b0;
    end else if (ce_in) begin
      clk_prev_q <= s2_q[0];
      frm_prev_q <= s2_q[2];
      if (rx.ready)
        valid_q <= 1'b0;
      if (frm_fall) begin
        valid_q <= 1'b1;
        eof_q   <= 1'b1;
        crc_q   <= s2_q[3];
        cnt_q   <= 3'h0;
      end else if (rise && s2_q[2]) begin
        sh_q  <= {s2_q[1], sh_q[7:1]};
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          valid_q <= 1'b1;
          eof_q   <= 1'b0;
        end
      end
    end
  end
  assign rx.valid  = valid_q;
  assign rx.data   = sh_q;
  assign rx.eof    = eof_q;
  assign rx.crc_ok = crc_q;
endmodule

// *** verilog/tbah_link_tx.sv ***
// Link transmitter: shifts answer bytes out LSB first on falling link clock edges
`timescale 1ns/1ps
module tbah_link_tx (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic ce_in,
  input  wire logic link_clk_in,
  tbah_byte_if.snk  tx,
  output logic      link_tx_data_out,
  output logic      link_tx_en_out
);
  logic       s1_q, s2_q, prev_q, busy_q, last_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic       fall;
  // ==========================================================
  // Link clock sampled like any outside pin
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce_in) begin
      s1_q   <= link_clk_in;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end
  assign fall     = ~s2_q & prev_q;
  // Next byte is taken only once the eighth bit has been out a full period, so bytes run without gaps
  assign tx.ready = ce_in & fall & (~busy_q | (cnt_q == 3'h0 && !last_q));
  // ==========================================================
  // Shifter
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      busy_q           <= 1'b0;
      last_q           <= 1'b0;
      sh_q             <= 8'h00;
      cnt_q            <= 3'h0;
      link_tx_data_out <= 1'b0;
      link_tx_en_out   <= 1'b0;
    end else if (ce_in && fall) begin
      if (tx.valid && tx.ready) begin
        busy_q           <= 1'b1;
        last_q           <= tx.eof;
        sh_q             <= {1'b0, tx.data[7:1]};
        cnt_q            <= 3'h1;
        link_tx_data_out <= tx.data[0];
        link_tx_en_out   <= 1'b1;
      end else if (busy_q && cnt_q != 3'h0) begin
        sh_q             <= {1'b0, sh_q[7:1]};
        cnt_q            <= cnt_q + 3'h1;
        link_tx_data_out <= sh_q[0];
      end else begin
        busy_q           <= 1'b0;
        link_tx_data_out <= 1'b0;
        link_tx_en_out   <= 1'b0;
      end
    end
  end
endmodule

// *** verilog/tbah_core.sv ***
// Type B anticollision handler: state machine, AFI filter, slot draw and answer assembly
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "tbah_defs.svh"
module tbah_core (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic        link_clk_in,
  input  wire logic        link_data_in,
  input  wire logic        link_frame_in,
  input  wire logic        link_crc_ok_in,
  output logic             link_tx_data_out,
  output logic             link_tx_en_out
);
  tbah_byte_if rx_if ();
  tbah_byte_if tx_if ();

  tbah_pkg::tbah_state_t state_q;
  tbah_pkg::tbah_ans_t   ans_kind;
  logic [7:0]  afi_q;
  logic [31:0] uid_lo_q, uid_hi_q, app_q;
  logic [15:0] lfsr_q;
  logic [3:0]  r_q, cid_q, r_new;
  logic [7:0]  rx_buf_q [`TBAH_RX_KEEP];
  logic [7:0]  tx_buf_q [`TBAH_TX_KEEP];
  logic [4:0]  rx_cnt_q;
  logic        over_q, addr_hit_q;
  logic        tx_busy_q;
  logic [3:0]  tx_idx_q, tx_len_q;
  logic        fr_done, fr_ok, send;
  logic        is_req, n_ok, wupb, afi_hit, req_take, mark_hit, halt_hit, attr_hit, desel_hit, blk_hit;
  logic [2:0]  n_code;
  logic [3:0]  n_mask;
  logic        pupi_ok;

  // ==========================================================
  // Link serialisers
  tbah_link_rx u_rx (
    .clk_in         (clk_in),
    .sys_rst_in     (sys_rst_in),
    .ce_in          (ce_in),
    .link_clk_in    (link_clk_in),
    .link_data_in   (link_data_in),
    .link_frame_in  (link_frame_in),
    .link_crc_ok_in (link_crc_ok_in),
    .rx             (rx_if.src)
  );
  tbah_link_tx u_tx (
    .clk_in           (clk_in),
    .sys_rst_in       (sys_rst_in),
    .ce_in            (ce_in),
    .link_clk_in      (link_clk_in),
    .tx               (tx_if.snk),
    .link_tx_data_out (link_tx_data_out),
    .link_tx_en_out   (link_tx_en_out)
  );
  // Bytes are consumed as soon as they appear
  assign rx_if.ready = ce_in;

  // ==========================================================
  // Frame collection; only the first bytes are kept, length is counted to the limit
  assign fr_done = ce_in & rx_if.valid & rx_if.eof;
  assign fr_ok   = fr_done & rx_if.crc_ok & ~over_q;
  generate
    for (genvar i = 0; i < `TBAH_RX_KEEP; i++) begin : g_rxb
      always_ff @(posedge clk_in) begin
        if (sys_rst_in)
          rx_buf_q[i] <= 8'h00;
        else if (ce_in && rx_if.valid && !rx_if.eof && rx_cnt_q == 5'(i))
          rx_buf_q[i] <= rx_if.data;
      end
    end
  endgenerate
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_cnt_q <= 5'h00;
      over_q   <= 1'b0;
    end else if (ce_in && rx_if.valid) begin
      if (rx_if.eof) begin
        rx_cnt_q <= 5'h00;
        over_q   <= 1'b0;
      end else if (rx_cnt_q == `TBAH_MAX_FRAME) begin
        over_q <= 1'b1;
      end else begin
        rx_cnt_q <= rx_cnt_q + 5'h01;
      end
    end
  end

  // ==========================================================
  // Free-running generator; runs even when no request is pending
  always_ff @(posedge clk_in) begin
    if (sys_rst_in)
      lfsr_q <= `TBAH_LFSR_SEED;
    else if (ce_in)
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end

  // ==========================================================
  // Request decode
  always_comb begin
    is_req  = (rx_cnt_q >= 5'h03) && (rx_buf_q[0] == `TBAH_CMD_REQ);
    n_code  = rx_buf_q[2][2:0];
    n_ok    = (n_code <= `TBAH_N_MAX_CODE);
    wupb    = rx_buf_q[2][`TBAH_PAR_WUPB];
    n_mask  = 4'((5'h01 << n_code) - 5'h01);
    r_new   = lfsr_q[3:0] & n_mask;
    // AFI filter
    if (rx_buf_q[1] == 8'h00)
      afi_hit = 1'b1;
    else if (rx_buf_q[1][3:0] == 4'h0)
      afi_hit = (rx_buf_q[1][7:4] == afi_q[7:4]);
    else
      afi_hit = (rx_buf_q[1] == afi_q);
    pupi_ok  = ({rx_buf_q[4], rx_buf_q[3], rx_buf_q[2], rx_buf_q[1]} == uid_lo_q);
    req_take = fr_ok && is_req && n_ok && state_q != tbah_pkg::TBAH_ACTIVE
               && !(state_q == tbah_pkg::TBAH_HALT && !wupb);
    mark_hit = fr_ok && rx_cnt_q == 5'h01 && rx_buf_q[0][3:0] == `TBAH_MARK_LOW
               && rx_buf_q[0][7:4] != 4'h0 && state_q == tbah_pkg::TBAH_WAIT
               && rx_buf_q[0][7:4] == r_q;
    halt_hit = fr_ok && rx_cnt_q == 5'h05 && rx_buf_q[0] == `TBAH_CMD_HALT
               && pupi_ok && state_q == tbah_pkg::TBAH_READY;
    attr_hit = fr_ok && rx_cnt_q >= 5'h09 && rx_buf_q[0] == `TBAH_CMD_ATTRIB
               && pupi_ok && state_q == tbah_pkg::TBAH_READY;
    desel_hit = fr_ok && state_q == tbah_pkg::TBAH_ACTIVE
                && ((rx_cnt_q == 5'h01 && rx_buf_q[0] == `TBAH_CMD_DESEL && cid_q == 4'h0)
                 || (rx_cnt_q == 5'h02 && rx_buf_q[0] == `TBAH_CMD_DESEL_C
                     && rx_buf_q[1][3:0] == cid_q));
    // Other ACTIVE frames belong to the block protocol; only their addressing is checked here
    blk_hit = fr_ok && state_q == tbah_pkg::TBAH_ACTIVE && !desel_hit
              && ((rx_buf_q[0][`TBAH_PCB_CID] && rx_cnt_q >= 5'h02 && rx_buf_q[1][3:0] == cid_q)
               || (!rx_buf_q[0][`TBAH_PCB_CID] && cid_q == 4'h0));
  end

  // ==========================================================
  // Protocol state
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= tbah_pkg::TBAH_IDLE;
      r_q     <= 4'h0;
      cid_q   <= 4'h0;
    end else if (ce_in) begin
      if (req_take) begin
        if (afi_hit) begin
          r_q <= r_new;
          if (n_code == 3'h0 || r_new == 4'h0)
            state_q <= tbah_pkg::TBAH_READY;
          else
            state_q <= tbah_pkg::TBAH_WAIT;
        end else begin
          state_q <= tbah_pkg::TBAH_IDLE;
        end
      end else if (mark_hit) begin
        state_q <= tbah_pkg::TBAH_READY;
      end else if (halt_hit) begin
        state_q <= tbah_pkg::TBAH_HALT;
      end else if (attr_hit) begin
        state_q <= tbah_pkg::TBAH_ACTIVE;
        cid_q   <= rx_buf_q[8][3:0];
      end else if (desel_hit) begin
        state_q <= tbah_pkg::TBAH_HALT;
      end
    end
  end

  // ==========================================================
  // Answer selection
  always_comb begin
    send     = 1'b0;
    ans_kind = tbah_pkg::TBAH_ANS_ATQB;
    if ((req_take && afi_hit && (n_code == 3'h0 || r_new == 4'h0)) || mark_hit) begin
      send = 1'b1;
    end else if (halt_hit) begin
      send     = 1'b1;
      ans_kind = tbah_pkg::TBAH_ANS_HALT;
    end else if (attr_hit) begin
      send     = 1'b1;
      ans_kind = tbah_pkg::TBAH_ANS_ATTR;
    end else if (desel_hit) begin
      send     = 1'b1;
      ans_kind = tbah_pkg::TBAH_ANS_DESL;
    end
  end

  // ==========================================================
  // Answer buffer and feed to the transmitter
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int k = 0; k < `TBAH_TX_KEEP; k++)
        tx_buf_q[k] <= 8'h00;
      tx_busy_q <= 1'b0;
      tx_idx_q  <= 4'h0;
      tx_len_q  <= 4'h0;
    end else if (ce_in) begin
      if (send && !tx_busy_q) begin
        tx_busy_q <= 1'b1;
        tx_idx_q  <= 4'h0;
        case (ans_kind)
          tbah_pkg::TBAH_ANS_ATQB: begin
            tx_buf_q[0]  <= `TBAH_ATQB_IND;
            tx_buf_q[1]  <= uid_lo_q[7:0];
            tx_buf_q[2]  <= uid_lo_q[15:8];
            tx_buf_q[3]  <= uid_lo_q[23:16];
            tx_buf_q[4]  <= uid_lo_q[31:24];
            tx_buf_q[5]  <= app_q[7:0];
            tx_buf_q[6]  <= app_q[15:8];
            tx_buf_q[7]  <= app_q[23:16];
            tx_buf_q[8]  <= app_q[31:24];
            tx_buf_q[9]  <= `TBAH_PI_RATE;
            tx_buf_q[10] <= `TBAH_PI_SIZE;
            tx_buf_q[11] <= {`TBAH_PI_FWI, `TBAH_PI_ADC, `TBAH_PI_FO};
            tx_len_q     <= 4'hc;
          end
          tbah_pkg::TBAH_ANS_HALT: begin
            tx_buf_q[0] <= `TBAH_HALT_ANS;
            tx_len_q    <= 4'h1;
          end
          tbah_pkg::TBAH_ANS_ATTR: begin
            tx_buf_q[0] <= {4'h0, rx_buf_q[8][3:0]};
            tx_len_q    <= 4'h1;
          end
          default: begin
            tx_buf_q[0] <= rx_buf_q[0];
            tx_buf_q[1] <= rx_buf_q[1];
            tx_len_q    <= 4'(rx_cnt_q);
          end
        endcase
      end else if (tx_busy_q && tx_if.ready) begin
        if (tx_idx_q == tx_len_q - 4'h1)
          tx_busy_q <= 1'b0;
        else
          tx_idx_q <= tx_idx_q + 4'h1;
      end
    end
  end
  assign tx_if.valid  = tx_busy_q;
  assign tx_if.data   = tx_buf_q[tx_idx_q];
  assign tx_if.eof    = (tx_idx_q == tx_len_q - 4'h1);
  assign tx_if.crc_ok = 1'b1;

  // ==========================================================
  // Register writes; the addressed flag is sticky, a new hit beats a clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      afi_q      <= `TBAH_AFI_RST;
      uid_lo_q   <= `TBAH_UID_RST;
      uid_hi_q   <= `TBAH_UID_RST;
      app_q      <= `TBAH_APP_RST;
      addr_hit_q <= 1'b0;
    end else if (ce_in) begin
      if (reg_wr_in) begin
        case (reg_addr_in)
          `TBAH_REG_AFI:    afi_q    <= reg_wdata_in[7:0];
          `TBAH_REG_UID_LO: uid_lo_q <= reg_wdata_in;
          `TBAH_REG_UID_HI: uid_hi_q <= reg_wdata_in;
          `TBAH_REG_APP:    app_q    <= reg_wdata_in;
          default: ;
        endcase
      end
      if (blk_hit)
        addr_hit_q <= 1'b1;
      else if (reg_wr_in && reg_addr_in == `TBAH_REG_STATUS && reg_wdata_in[12])
        addr_hit_q <= 1'b0;
    end
  end

  // ==========================================================
  // Register reads, answered one cycle later; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      if (reg_rd_in) begin
        case (reg_addr_in)
          `TBAH_REG_AFI:    reg_rdata_out <= {24'h000000, afi_q};
          `TBAH_REG_UID_LO: reg_rdata_out <= uid_lo_q;
          `TBAH_REG_UID_HI: reg_rdata_out <= uid_hi_q;
          `TBAH_REG_APP:    reg_rdata_out <= app_q;
          `TBAH_REG_STATUS: reg_rdata_out <= {18'h00000, tx_busy_q, addr_hit_q, cid_q, r_q, 1'b0, state_q};
          default:          reg_rdata_out <= 32'h0000_0000;
        endcase
      end else begin
        reg_rdata_out <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Checks
  active_entry_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_q == tbah_pkg::TBAH_ACTIVE && $past(state_q) != tbah_pkg::TBAH_ACTIVE)
    |-> ($past(state_q) == tbah_pkg::TBAH_READY && $past(rx_buf_q[0]) == `TBAH_CMD_ATTRIB))
    else $error("ACTIVE entered other than from READY on ATTRIB");
  active_answer_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && attr_hit && !tx_busy_q) |=> (tx_busy_q && tx_len_q == 4'h1 && tx_buf_q[0][3:0] == cid_q))
    else $error("No confirmation queued on entering ACTIVE");
  cid_store_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && attr_hit) |=> (cid_q == $past(rx_buf_q[8][3:0])))
    else $error("Card identifier not stored from ATTRIB");
  deselect_halt_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ($past(state_q) == tbah_pkg::TBAH_ACTIVE && state_q != tbah_pkg::TBAH_ACTIVE)
    |-> (state_q == tbah_pkg::TBAH_HALT))
    else $error("ACTIVE left to a state other than HALT");
  halt_reqb_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && fr_done && state_q == tbah_pkg::TBAH_HALT && is_req && !wupb) |=> (state_q == tbah_pkg::TBAH_HALT))
    else $error("HALT reacted to REQB");
  afi_wild_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && req_take && rx_buf_q[1] == 8'h00) |=> (state_q inside {tbah_pkg::TBAH_READY, tbah_pkg::TBAH_WAIT}))
    else $error("AFI 00h request not processed");
  single_slot_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && req_take && afi_hit && n_code == 3'h0) |=> (state_q == tbah_pkg::TBAH_READY && tx_busy_q))
    else $error("Single slot request did not answer at once");
  slot_range_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && req_take && afi_hit) |=> (r_q <= $past(n_mask)))
    else $error("Drawn slot outside the slot count");
  atqb_head_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && mark_hit && !tx_busy_q) |=> (tx_buf_q[0] == `TBAH_ATQB_IND && tx_len_q == 4'hc))
    else $error("Slot marker answer is not an ATQB");
  crc_drop_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && fr_done && !rx_if.crc_ok) |=> ($stable(state_q) && $stable(r_q)))
    else $error("Frame with bad CRC changed the state");
endmodule

// *** tb/tbah_reader.sv ***
// Reader model: sends request frames on the link and captures the answer bits
`timescale 1ns/1ps
module tbah_reader (
  input  wire logic tx_data_in,
  input  wire logic tx_en_in,
  output logic      lclk_out,
  output logic      ldata_out,
  output logic      frame_out,
  output logic      crc_ok_out
);
  logic [95:0] rx_v;
  int          rx_n;
  // Link clock stands still between exchanges
  initial begin
    lclk_out = 1'b0;
    ldata_out = 1'b0;
    frame_out = 1'b0;
    crc_ok_out = 1'b1;
  end
  // One exchange at 200 ns per bit, answer collected LSB first
  task automatic xfer(input logic [95:0] q, input int qn, input logic ok);
    int n;
    n = 0;
    rx_v = '0;
    for (int i = 0; i < qn * 8; i++) begin
      ldata_out = q[i];
      frame_out = 1'b1;
      #100 lclk_out = 1'b1;
      #100 lclk_out = 1'b0;
    end
    crc_ok_out = ok;
    #50 frame_out = 1'b0;
    ldata_out = ~ldata_out; // Released line must not keep the last bit
    // Far shorter than the allowed wait, the device answers early
    repeat (120) begin
      #100 if (tx_en_in) begin
        rx_v = {tx_data_in, rx_v[95:1]};
        n++;
      end
      lclk_out = 1'b1;
      #100 lclk_out = 1'b0;
    end
    rx_v = rx_v >> (96 - n);
    rx_n = n / 8;
    crc_ok_out = 1'b1;
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the Type B anticollision handler core
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] UID = 32'h8a4c2e16;
  localparam logic [95:0] ATQB = {8'h71, 8'h21, 8'h77, 32'h5b3d7f91, UID, 8'h50};
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [3:0]  r;
  logic        lclk, ldat, lfrm, lok, txd, txe;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #12.5 clk_in = ~clk_in;
  tbah_core i_tbah_core (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .link_clk_in(lclk), .link_data_in(ldat), .link_frame_in(lfrm), .link_crc_ok_in(lok),
    .link_tx_data_out(txd), .link_tx_en_out(txe));
  tbah_reader i_tbah_reader (.tx_data_in(txd), .tx_en_in(txe), .lclk_out(lclk), .ldata_out(ldat),
    .frame_out(lfrm), .crc_ok_out(lok));
  task automatic final_report;
    $display("Counts: %0d mismatches in %0d comparisons", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cut a hang short; the run needs roughly 20000 to 25000 cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in) {addr, wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge clk_in) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in) {addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_in) reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Request, then answer length, answer bytes and state
  task automatic ex(input logic [95:0] q, input int qn, input logic ok, input logic [95:0] a, input int an,
                    input logic [2:0] st);
    i_tbah_reader.xfer(q, qn, ok);
    chk(96'(i_tbah_reader.rx_n), 96'(an));
    chk(i_tbah_reader.rx_v, a);
    rd(8'h10);
    chk(96'(d[2:0]), 96'(st));
    $display("test done at %0t", $time);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    wr(8'h04, UID);
    wr(8'h0c, 32'h5b3d7f91);
    wr(8'h00, 32'h35);
    wr(8'h20, 32'hffffffff);
    rd(8'h20);
    chk(96'(d), 96'h0);
    ex(96'h000005, 3, 1'b1, ATQB, 12, 3'h3);
    ex(96'h003605, 3, 1'b1, 96'h0, 0, 3'h0);
    ex({8'h03, 8'h01, 16'h0, UID, 8'h1d}, 9, 1'b1, 96'h0, 0, 3'h0);
    ex(96'h003005, 3, 1'b1, ATQB, 12, 3'h3);
    ex(96'h003605, 3, 1'b0, 96'h0, 0, 3'h3);
    ex(96'h003505, 3, 1'b1, ATQB, 12, 3'h3);
    ex({8'h03, 8'h01, 16'h0, UID, 8'h1d}, 9, 1'b1, 96'h03, 1, 3'h2);
    rd(8'h10);
    chk(96'(d[11:8]), 96'h3);
    ex(96'h000005, 3, 1'b1, 96'h0, 0, 3'h2);
    ex(96'h030a, 2, 1'b1, 96'h0, 0, 3'h2);
    rd(8'h10);
    chk(96'(d[12]), 96'h1);
    wr(8'h10, 32'h0000_1000);
    rd(8'h10);
    chk(96'(d[12]), 96'h0);
    ex(96'h03ca, 2, 1'b1, 96'h03ca, 2, 3'h6);
    ex(96'h000005, 3, 1'b1, 96'h0, 0, 3'h6);
    ex(96'h080005, 3, 1'b1, ATQB, 12, 3'h3);
    for (int c = 1; c < 5; c++) begin
      i_tbah_reader.xfer({64'h0, 5'h0, 3'(c), 16'h0005}, 3, 1'b1);
      rd(8'h10);
      r = d[7:4];
      chk(96'(r & ~4'((1 << c) - 1)), 96'h0);
      chk(96'(i_tbah_reader.rx_n), (r == 4'h0) ? 96'd12 : 96'd0);
      chk(96'(d[2:0]), (r == 4'h0) ? 96'h3 : 96'h1);
      if (r != 4'h0) ex(96'({r, 4'h5}), 1, 1'b1, ATQB, 12, 3'h3);
    end
    ex(96'h050005, 3, 1'b1, 96'h0, 0, 3'h3);
    final_report();
  end
endmodule
